/* hdl/block_sleep_enable_bank.sv */
// Power, clock and reset register bank: sleep enables, clock-needed
// status, sleep control and reset enable storage.
// Assumes one 40 MHz clock, synchronous inputs, and a bus master that
// never issues read and write strobes together.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module block_sleep_enable_bank
    import sleep_bank_pkg::*;
#(
    parameter int          ADDR_W = 8,
    parameter logic [31:0] OSC_ID = 32'h00000000  // Arbitrary identity value
)(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Register bus
    input  wire bus_req_type       bus_req,
    output logic [31:0]            rd_data,
    // Peripheral handshakes
    input  wire logic [31:0]       periph_clk_req,
    input  wire logic [31:0]       host_clk_req,
    input  wire logic [31:0]       periph_clk_req_two,
    input  wire logic [1:0]        timer_auto_reload,
    input  wire logic [1:0]        timer_halted,
    input  wire logic [31:0]       pwr_rst_status_in,
    input  wire logic              cpu_sleep_instr,
    // Sleep commands and sleep status
    output logic [31:0]            sleep_cmd,
    output logic [31:0]            host_sleep_cmd,
    output logic [31:0]            sleep_cmd_two,
    output logic [31:0]            periph_asleep,
    output logic                   chip_sleep,
    // Control register contents
    output logic [31:0]            sys_sleep_ctrl,
    output logic [31:0]            proc_clk_ctrl,
    output logic [31:0]            slow_clk_ctrl,
    output logic [31:0]            host_rst_en,
    output logic [31:0]            rst_en,
    output logic [31:0]            rst_en_two,
    output logic [31:0]            power_reset_control
);

    // --------------------
    // Elaboration checks
    // --------------------
    if (ADDR_W != 8) begin : g_bad_addr
        $error("block_sleep_enable_bank: ADDR_W must be 8");
    end

    // --------------------
    // Address decode helper
    // --------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // --------------------
    // Registers
    // --------------------
    logic [31:0] sleep_en_reg;
    logic [31:0] host_sleep_en_reg;
    logic [31:0] sys_sleep_ctrl_reg;
    logic [31:0] proc_clk_ctrl_reg;
    logic [31:0] sleep_en_two_reg;
    logic [31:0] slow_clk_ctrl_reg;
    logic [31:0] host_rst_en_reg;
    logic [31:0] rst_en_reg;
    logic [31:0] rst_en_two_reg;
    logic [31:0] power_reset_control_reg;
    logic [31:0] clk_needed_reg;
    logic [31:0] host_clk_needed_reg;
    logic [31:0] clk_needed_two_reg;
    logic [31:0] pwr_rst_sts_reg;
    logic [31:0] sleep_cmd_reg;
    logic [31:0] host_sleep_cmd_reg;
    logic [31:0] sleep_cmd_two_reg;
    logic [31:0] periph_asleep_reg;
    logic        chip_sleep_reg;
    logic [31:0] rd_data_reg;

    // --------------------
    // Write decode
    // --------------------
    wire logic        wr      = bus_req.wr;
    wire logic        rd      = bus_req.rd;
    wire logic [7:0]  addr    = bus_req.addr;
    wire logic [31:0] wdata   = bus_req.wdata;

    wire logic wr_sleep_en  = wr && hit(addr, OFF_SLEEP_EN);
    wire logic wr_host_en   = wr && hit(addr, OFF_HOST_SLEEP_EN);
    wire logic wr_sys_ctrl  = wr && hit(addr, OFF_SYS_SLEEP_CTRL);
    wire logic wr_proc_clk  = wr && hit(addr, OFF_PROC_CLK_CTRL);
    wire logic wr_sleep_two = wr && hit(addr, OFF_SLEEP_EN_TWO);
    wire logic wr_slow_clk  = wr && hit(addr, OFF_SLOW_CLK_CTRL);
    wire logic wr_host_rst  = wr && hit(addr, OFF_HOST_RST_EN);
    wire logic wr_rst_en    = wr && hit(addr, OFF_RST_EN);
    wire logic wr_rst_two   = wr && hit(addr, OFF_RST_EN_TWO);
    wire logic wr_pwr_ctrl  = wr && hit(addr, OFF_POWER_RESET_CONTROL);

    // --------------------
    // Next values of the writable registers
    // --------------------
    // Reserved sleep enable bits are dropped on write
    wire logic [31:0] sleep_en_next =
        wr_sleep_en ? (wdata & SLEEP_EN_MASK) : sleep_en_reg;
    wire logic [31:0] host_sleep_en_next =
        wr_host_en ? wdata : host_sleep_en_reg;
    wire logic [31:0] sys_sleep_ctrl_next =
        wr_sys_ctrl ? (wdata & SYS_SLEEP_MASK) : sys_sleep_ctrl_reg;
    wire logic [31:0] proc_clk_ctrl_next =
        wr_proc_clk ? wdata : proc_clk_ctrl_reg;
    wire logic [31:0] sleep_en_two_next =
        wr_sleep_two ? wdata : sleep_en_two_reg;
    wire logic [31:0] slow_clk_ctrl_next =
        wr_slow_clk ? wdata : slow_clk_ctrl_reg;
    wire logic [31:0] host_rst_en_next =
        wr_host_rst ? wdata : host_rst_en_reg;
    wire logic [31:0] rst_en_next =
        wr_rst_en ? wdata : rst_en_reg;
    wire logic [31:0] rst_en_two_next =
        wr_rst_two ? wdata : rst_en_two_reg;
    wire logic [31:0] power_reset_control_next =
        wr_pwr_ctrl ? wdata : power_reset_control_reg;

    // --------------------
    // Clock-needed merge
    // --------------------
    wire logic [31:0] clk_needed_next;

    clock_request_merge u_merge (
        .periph_clk_req    (periph_clk_req),
        .timer_auto_reload (timer_auto_reload),
        .timer_halted      (timer_halted),
        .bank_access       (wr | rd),
        .clk_needed        (clk_needed_next)
    );

    // --------------------
    // Effective sleep commands
    // --------------------
    // Sleep-all commands every implemented block at once
    wire logic        sleep_all = sys_sleep_ctrl_reg[SYS_SLEEP_ALL_BIT];
    wire logic [31:0] all_word  = {32{sleep_all}};

    // Timers, register bank, PWMs and the other peripherals
    wire logic [31:0] sleep_cmd_next =
        sleep_en_reg | (all_word & SLEEP_EN_MASK);
    wire logic [31:0] host_sleep_cmd_next = host_sleep_en_reg | all_word;
    wire logic [31:0] sleep_cmd_two_next  = sleep_en_two_reg | all_word;

    // A block is asleep once commanded and no longer asking for clock
    wire logic [31:0] periph_asleep_next =
        sleep_cmd_reg & ~clk_needed_reg & SLEEP_EN_MASK;

    // --------------------
    // Chip sleep qualification
    // --------------------
    wire logic all_commanded =
        ((sleep_cmd_reg & SLEEP_EN_MASK) == SLEEP_EN_MASK) &&
        (host_sleep_cmd_reg == {32{1'b1}}) &&
        (sleep_cmd_two_reg == {32{1'b1}});
    wire logic none_needed =
        (clk_needed_reg == WORD_ZERO) &&
        (host_clk_needed_reg == WORD_ZERO) &&
        (clk_needed_two_reg == WORD_ZERO);
    // A bus access wakes the chip on the next edge, a new clock request one edge later
    wire logic chip_sleep_next =
        all_commanded && none_needed && cpu_sleep_instr && !(wr | rd);

    // --------------------
    // Read multiplexer
    // --------------------
    logic [31:0] rd_mux;

    // Test and unmapped words read zero
    always_comb begin
        if (hit(addr, OFF_SLEEP_EN))
            rd_mux = sleep_en_reg & SLEEP_EN_MASK;
        else if (hit(addr, OFF_CLK_NEEDED))
            rd_mux = clk_needed_reg;
        else if (hit(addr, OFF_HOST_SLEEP_EN))
            rd_mux = host_sleep_en_reg;
        else if (hit(addr, OFF_HOST_CLK_NEED))
            rd_mux = host_clk_needed_reg;
        else if (hit(addr, OFF_SYS_SLEEP_CTRL))
            rd_mux = sys_sleep_ctrl_reg;
        else if (hit(addr, OFF_PROC_CLK_CTRL))
            rd_mux = proc_clk_ctrl_reg;
        else if (hit(addr, OFF_SLEEP_EN_TWO))
            rd_mux = sleep_en_two_reg;
        else if (hit(addr, OFF_CLK_NEED_TWO))
            rd_mux = clk_needed_two_reg;
        else if (hit(addr, OFF_SLOW_CLK_CTRL))
            rd_mux = slow_clk_ctrl_reg;
        else if (hit(addr, OFF_OSC_ID))
            rd_mux = OSC_ID;
        else if (hit(addr, OFF_PWR_RST_STS))
            rd_mux = pwr_rst_sts_reg;
        else if (hit(addr, OFF_HOST_RST_EN))
            rd_mux = host_rst_en_reg;
        else if (hit(addr, OFF_RST_EN))
            rd_mux = rst_en_reg;
        else if (hit(addr, OFF_RST_EN_TWO))
            rd_mux = rst_en_two_reg;
        else if (hit(addr, OFF_POWER_RESET_CONTROL))
            rd_mux = power_reset_control_reg;
        else
            rd_mux = WORD_ZERO;
    end

    // Read data stand only in the cycle after the strobe
    wire logic [31:0] rd_data_next = rd ? rd_mux : WORD_ZERO;

    // --------------------
    // Control registers
    // --------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_en_reg       <= SLEEP_EN_RESET;
            host_sleep_en_reg  <= CTRL_RESET;
            sys_sleep_ctrl_reg <= CTRL_RESET;
            proc_clk_ctrl_reg  <= CTRL_RESET;
            sleep_en_two_reg   <= CTRL_RESET;
            slow_clk_ctrl_reg  <= CTRL_RESET;
        end else begin
            sleep_en_reg       <= sleep_en_next;
            host_sleep_en_reg  <= host_sleep_en_next;
            sys_sleep_ctrl_reg <= sys_sleep_ctrl_next;
            proc_clk_ctrl_reg  <= proc_clk_ctrl_next;
            sleep_en_two_reg   <= sleep_en_two_next;
            slow_clk_ctrl_reg  <= slow_clk_ctrl_next;
        end
    end

    // Reset enable and reset control storage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            host_rst_en_reg  <= CTRL_RESET;
            rst_en_reg       <= CTRL_RESET;
            rst_en_two_reg   <= CTRL_RESET;
            power_reset_control_reg <= CTRL_RESET;
        end else begin
            host_rst_en_reg  <= host_rst_en_next;
            rst_en_reg       <= rst_en_next;
            rst_en_two_reg   <= rst_en_two_next;
            power_reset_control_reg <= power_reset_control_next;
        end
    end

    // --------------------
    // Status sampling
    // --------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_needed_reg      <= CLK_NEED_RESET;
            host_clk_needed_reg <= WORD_ZERO;
            clk_needed_two_reg  <= WORD_ZERO;
            pwr_rst_sts_reg     <= WORD_ZERO;
        end else begin
            clk_needed_reg      <= clk_needed_next;
            host_clk_needed_reg <= host_clk_req;
            clk_needed_two_reg  <= periph_clk_req_two;
            pwr_rst_sts_reg     <= pwr_rst_status_in;
        end
    end

    // --------------------
    // Command, sleep and read data outputs
    // --------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_cmd_reg      <= WORD_ZERO;
            host_sleep_cmd_reg <= WORD_ZERO;
            sleep_cmd_two_reg  <= WORD_ZERO;
            periph_asleep_reg  <= WORD_ZERO;
            chip_sleep_reg     <= 1'b0;
            rd_data_reg        <= WORD_ZERO;
        end else begin
            sleep_cmd_reg      <= sleep_cmd_next;
            host_sleep_cmd_reg <= host_sleep_cmd_next;
            sleep_cmd_two_reg  <= sleep_cmd_two_next;
            periph_asleep_reg  <= periph_asleep_next;
            chip_sleep_reg     <= chip_sleep_next;
            rd_data_reg        <= rd_data_next;
        end
    end

    // --------------------
    // Output connections
    // --------------------
    assign rd_data        = rd_data_reg;
    assign sleep_cmd      = sleep_cmd_reg;
    assign host_sleep_cmd = host_sleep_cmd_reg;
    assign sleep_cmd_two  = sleep_cmd_two_reg;
    assign periph_asleep  = periph_asleep_reg;
    assign chip_sleep     = chip_sleep_reg;
    assign sys_sleep_ctrl = sys_sleep_ctrl_reg;
    assign proc_clk_ctrl  = proc_clk_ctrl_reg;
    assign slow_clk_ctrl  = slow_clk_ctrl_reg;
    assign host_rst_en    = host_rst_en_reg;
    assign rst_en         = rst_en_reg;
    assign rst_en_two     = rst_en_two_reg;
    assign power_reset_control   = power_reset_control_reg;

endmodule : block_sleep_enable_bank
`default_nettype wire

/* hdl/clock_request_merge.sv */
// Merges peripheral clock requests into the clock-needed status word.
// Assumes all inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module clock_request_merge
    import sleep_bank_pkg::*;
(
    // Raw requests from peripherals
    input  wire logic [31:0] periph_clk_req,
    // Basic timer modes
    input  wire logic [1:0]  timer_auto_reload,
    input  wire logic [1:0]  timer_halted,
    // Register bank activity
    input  wire logic        bank_access,
    // Merged result
    output logic [31:0]      clk_needed
);

    // ------------------------------------------------------------------
    // Forced requests
    // ------------------------------------------------------------------
    // Running auto-reload timers hold their request high
    wire logic [1:0] timer_force = timer_auto_reload & ~timer_halted;

    // Reserved positions read zero; bank requests during its own access
    always_comb begin
        clk_needed = periph_clk_req & SLEEP_EN_MASK;
        clk_needed[BIT_TIMER_SECOND] = periph_clk_req[BIT_TIMER_SECOND] | timer_force[1];
        clk_needed[BIT_TIMER_FIRST]  = periph_clk_req[BIT_TIMER_FIRST] | timer_force[0];
        clk_needed[BIT_REG_BANK]     = periph_clk_req[BIT_REG_BANK] | bank_access;
    end

endmodule : clock_request_merge
`default_nettype wire

/* hdl/sleep_bank_pkg.sv */
// Constants and carrier types for the sleep enable register bank.
// Assumes a single system clock and a synchronous active-low reset.

package sleep_bank_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TEST_A         = 8'h00;
    localparam logic [7:0] OFF_TEST_B         = 8'h04;
    localparam logic [7:0] OFF_SLEEP_EN       = 8'h08;
    localparam logic [7:0] OFF_CLK_NEEDED     = 8'h0C;
    localparam logic [7:0] OFF_HOST_SLEEP_EN  = 8'h10;
    localparam logic [7:0] OFF_HOST_CLK_NEED  = 8'h14;
    localparam logic [7:0] OFF_SYS_SLEEP_CTRL = 8'h18;
    localparam logic [7:0] OFF_PROC_CLK_CTRL  = 8'h20;
    localparam logic [7:0] OFF_SLEEP_EN_TWO   = 8'h24;
    localparam logic [7:0] OFF_CLK_NEED_TWO   = 8'h28;
    localparam logic [7:0] OFF_SLOW_CLK_CTRL  = 8'h2C;
    localparam logic [7:0] OFF_OSC_ID         = 8'h30;
    localparam logic [7:0] OFF_PWR_RST_STS    = 8'h34;
    localparam logic [7:0] OFF_TEST_C         = 8'h38;
    localparam logic [7:0] OFF_HOST_RST_EN    = 8'h3C;
    localparam logic [7:0] OFF_RST_EN         = 8'h40;
    localparam logic [7:0] OFF_RST_EN_TWO     = 8'h44;
    localparam logic [7:0] OFF_POWER_RESET_CONTROL   = 8'h48;

    // ------------------------------------------------------------------
    // Controller sleep enable field positions
    // ------------------------------------------------------------------
    localparam int BIT_TIMER_SECOND = 31;
    localparam int BIT_TIMER_FIRST  = 30;
    localparam int BIT_REG_BANK     = 29;
    localparam int BIT_PWM_HI_TOP   = 26;
    localparam int BIT_PWM_HI_BOT   = 20;
    localparam int BIT_TACH_ONE     = 11;
    localparam int BIT_SMBUS_ZERO   = 10;
    localparam int BIT_WATCHDOG     = 9;
    localparam int BIT_PROCESSOR    = 8;
    localparam int BIT_TRACE_PORT   = 7;
    localparam int BIT_DMA          = 6;
    localparam int BIT_POWER_MGMT   = 5;
    localparam int BIT_PWM_ZERO     = 4;
    localparam int BIT_TACH_ZERO    = 2;
    localparam int BIT_PECI         = 1;
    localparam int BIT_INT_UNIT     = 0;

    // Implemented bits; 28:27, 19:12 and 3 are reserved
    localparam logic [31:0] SLEEP_EN_MASK  = 32'hE7F00FF7;
    localparam logic [31:0] SLEEP_EN_RESET = 32'h00000000;
    // Processor needs the clock out of reset
    localparam logic [31:0] CLK_NEED_RESET = 32'h00000100;
    localparam logic [31:0] WORD_ZERO      = 32'h00000000;

    // ------------------------------------------------------------------
    // System sleep control fields
    // ------------------------------------------------------------------
    localparam int          SYS_SLEEP_ALL_BIT = 3;
    localparam logic [31:0] SYS_SLEEP_MASK    = 32'h0000000F;
    localparam logic [31:0] CTRL_RESET        = 32'h00000000;

    // Register bus request carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

endpackage : sleep_bank_pkg

/* verification/periph_model.sv */
// Behavioural peripherals answering one sleep command word.
// Assumes busy levels come from the bench in step with ref_clk.
`timescale 1ns/1ps
`default_nettype none

module periph_model #(
    parameter logic [31:0] MASK = 32'hFFFFFFFF
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Sleep commands and pending work
    input  wire logic [31:0] sleep_cmd,
    input  wire logic [31:0] busy,
    // Clock requests
    output logic [31:0]      clk_req
);
    logic [31:0] slept_reg;
    logic [31:0] slept_next;

    // Sleeps once commanded and idle, stays so until released
    assign slept_next = sleep_cmd & (slept_reg | ~clk_req);

    // Requests clock only for pending work while awake
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slept_reg <= 32'h00000000;
            clk_req   <= 32'h00000000;
        end else begin
            slept_reg <= slept_next;
            clk_req   <= busy & ~slept_next & MASK;
        end
    end
endmodule : periph_model

`default_nettype wire

/* verification/sleep_bank_props.sv */
// Port checker for the sleep enable register bank.
// Assumes it is bound onto block_sleep_enable_bank below.
`timescale 1ns/1ps
`default_nettype none

module sleep_bank_props
    import sleep_bank_pkg::*;
(
    // Clock, reset and register bus
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire bus_req_type bus_req,
    input  wire logic [31:0] rd_data,
    // Timer and processor state
    input  wire logic [1:0]  timer_auto_reload,
    input  wire logic [1:0]  timer_halted,
    input  wire logic        cpu_sleep_instr,
    // Commands and sleep status
    input  wire logic [31:0] sleep_cmd,
    input  wire logic [31:0] host_sleep_cmd,
    input  wire logic [31:0] periph_asleep,
    input  wire logic        chip_sleep,
    input  wire logic [31:0] sys_sleep_ctrl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Read data only in the slot after a read
    rd_slot_zero_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h00000000)
        else $error("read data outside read slot");
    rsvd_read_zero_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFF_SLEEP_EN
        |-> (rd_data & ~SLEEP_EN_MASK) == 32'h00000000)
        else $error("reserved sleep enable bits read back set");
    rsvd_cmd_zero_a: assert property ((sleep_cmd & ~SLEEP_EN_MASK) == 32'h00000000)
        else $error("reserved sleep command bit set");
    // Written enable reaches the command two cycles on
    write_lands_a: assert property (bus_req.wr && bus_req.addr == OFF_SLEEP_EN
        && !sys_sleep_ctrl[SYS_SLEEP_ALL_BIT]
        |-> ##2 sleep_cmd == ($past(bus_req.wdata, 2) & SLEEP_EN_MASK))
        else $error("sleep command does not follow write");
    sleep_all_cmd_a: assert property (sys_sleep_ctrl[SYS_SLEEP_ALL_BIT]
        |=> (sleep_cmd & SLEEP_EN_MASK) == SLEEP_EN_MASK && host_sleep_cmd == 32'hFFFFFFFF)
        else $error("sleep all not applied");
    asleep_needs_cmd_a: assert property ((periph_asleep & ~$past(sleep_cmd)) == 32'h00000000)
        else $error("peripheral asleep without command");
    bank_awake_a: assert property (bus_req.wr || bus_req.rd |-> ##2 !periph_asleep[BIT_REG_BANK])
        else $error("register bank asleep during access");
    timer_awake_a: assert property ((timer_auto_reload[1] && !timer_halted[1])[*2]
        |=> !periph_asleep[BIT_TIMER_SECOND])
        else $error("reloading timer reported asleep");
    chip_cause_a: assert property (chip_sleep |-> $past(cpu_sleep_instr)
        && !$past(bus_req.wr) && !$past(bus_req.rd)
        && ($past(sleep_cmd) & SLEEP_EN_MASK) == SLEEP_EN_MASK)
        else $error("chip asleep without cause");

    // Main scenarios reached
    cover property (chip_sleep);
    cover property (sys_sleep_ctrl[SYS_SLEEP_ALL_BIT]);
    cover property (periph_asleep == SLEEP_EN_MASK);
endmodule : sleep_bank_props

bind block_sleep_enable_bank sleep_bank_props u_props (.ref_clk, .rst_n, .bus_req, .rd_data,
    .timer_auto_reload, .timer_halted, .cpu_sleep_instr, .sleep_cmd, .host_sleep_cmd,
    .periph_asleep, .chip_sleep, .sys_sleep_ctrl);

`default_nettype wire

/* verification/test_block_sleep_enable_bank.sv */
// Self-checking bench for the sleep enable register bank.
// Assumes the port checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none

module test_block_sleep_enable_bank
    import sleep_bank_pkg::*;
;
    localparam logic [31:0] OSC_VAL  = 32'h5A5A0001; // Arbitrary identity value
    localparam logic [31:0] BANK_BIT = 32'h20000000;
    logic              ref_clk;
    logic              rst_n             = 1'b0;
    logic              cpu_sleep_instr   = 1'b0;
    logic              chip_sleep;
    bus_req_type       bus_req           = '0;
    logic [1:0]        timer_auto_reload = 2'b00;
    logic [1:0]        timer_halted      = 2'b00;
    logic [31:0]       pwr_rst_status_in = 32'h00000000;
    logic [31:0]       busy_a            = 32'h00000000;
    logic [31:0]       busy_h            = 32'h00000000;
    logic [31:0]       busy_t            = 32'h00000000;
    logic [31:0]       rd_data, periph_clk_req, host_clk_req, periph_clk_req_two;
    logic [31:0]       sleep_cmd, host_sleep_cmd, sleep_cmd_two, periph_asleep, r, d;
    logic [7:0]        a;
    logic [31:0]       ro_e [5];
    logic [31:0]       ctl [7];
    logic [7:0]        ctl_a [7] = '{OFF_SYS_SLEEP_CTRL, OFF_PROC_CLK_CTRL, OFF_SLOW_CLK_CTRL,
                                     OFF_HOST_RST_EN, OFF_RST_EN, OFF_RST_EN_TWO, OFF_POWER_RESET_CONTROL};
    logic [7:0]        ro_a [5] = '{OFF_CLK_NEEDED, OFF_HOST_CLK_NEED, OFF_CLK_NEED_TWO,
                                    OFF_OSC_ID, OFF_PWR_RST_STS};
    logic [7:0]        offs [16] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24,
                                     8'h2C, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h09};
    int                n_errors = 0;
    int                tests_run = 0;
    int                seed = 50;
    int                i;

    // Design and peripherals on all three command words
    block_sleep_enable_bank #(.OSC_ID(OSC_VAL)) u_dut (.ref_clk, .rst_n, .bus_req, .rd_data,
        .periph_clk_req, .host_clk_req, .periph_clk_req_two, .timer_auto_reload,
        .timer_halted, .pwr_rst_status_in, .cpu_sleep_instr, .sleep_cmd, .host_sleep_cmd,
        .sleep_cmd_two, .periph_asleep, .chip_sleep, .sys_sleep_ctrl(ctl[0]),
        .proc_clk_ctrl(ctl[1]), .slow_clk_ctrl(ctl[2]), .host_rst_en(ctl[3]),
        .rst_en(ctl[4]), .rst_en_two(ctl[5]), .power_reset_control(ctl[6]));
    periph_model #(.MASK(SLEEP_EN_MASK)) u_pa (.ref_clk, .rst_n, .sleep_cmd,
        .busy(busy_a), .clk_req(periph_clk_req));
    periph_model u_ph (.ref_clk, .rst_n, .sleep_cmd(host_sleep_cmd), .busy(busy_h),
        .clk_req(host_clk_req));
    periph_model u_pt (.ref_clk, .rst_n, .sleep_cmd(sleep_cmd_two), .busy(busy_t),
        .clk_req(periph_clk_req_two));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Expected read-back after a write
    function automatic logic [31:0] exp_rw(input logic [7:0] ad, input logic [31:0] wd);
        case (ad)
            OFF_SLEEP_EN:       return wd & SLEEP_EN_MASK;
            OFF_SYS_SLEEP_CTRL: return wd & SYS_SLEEP_MASK;
            OFF_HOST_SLEEP_EN, OFF_PROC_CLK_CTRL, OFF_SLEEP_EN_TWO, OFF_SLOW_CLK_CTRL,
            OFF_HOST_RST_EN, OFF_RST_EN, OFF_RST_EN_TWO, OFF_POWER_RESET_CONTROL: return wd;
            default:            return 32'h00000000;
        endcase
    endfunction : exp_rw

    function automatic logic [31:0] pick(input bit s);
        return s ? {31'h0, chip_sleep} : periph_asleep;
    endfunction : pick

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge ref_clk);
        bus_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] ad, output logic [31:0] rd);
        @(posedge ref_clk);
        bus_req <= '{addr: ad, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 rd = rd_data;
    endtask : bus_rd

    // Bounded wait for a status word
    task automatic settle(input bit s, input logic [31:0] e);
        int n;
        n = 0;
        #1;
        while (pick(s) !== e && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(s ? "chip sleep" : "peripherals asleep", e, pick(s));
        if (pick(s) !== e) conclude();
    endtask : settle

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 16; i++) begin
            bus_rd(offs[i], r);
            chk("reset word", 32'h00000000, r);
        end
        $display("test reset done");
        for (i = 0; i < 32; i++) begin
            bus_wr(OFF_SLEEP_EN, 32'h1 << i);
            bus_rd(OFF_SLEEP_EN, r);
            chk("sleep enable", SLEEP_EN_MASK & (32'h1 << i), r);
            chk("sleep command", SLEEP_EN_MASK & (32'h1 << i), sleep_cmd);
        end
        $display("test walking bit done");
        for (i = 0; i < 40; i++) begin
            a = offs[$unsigned($random(seed)) % 16];
            d = $random(seed);
            bus_wr(a, d);
            bus_rd(a, r);
            chk("register word", exp_rw(a, d), r);
            for (int k = 0; k < 7; k++)
                if (ctl_a[k] == a) chk("control output", exp_rw(a, d), ctl[k]);
        end
        bus_wr(OFF_SYS_SLEEP_CTRL, 32'h00000000);
        $display("test random access done");
        busy_a <= $random(seed);
        busy_h <= $random(seed);
        busy_t <= $random(seed);
        pwr_rst_status_in <= $random(seed);
        repeat (4) @(posedge ref_clk);
        #1 ro_e = '{periph_clk_req & ~BANK_BIT, host_clk_req, periph_clk_req_two, OSC_VAL,
                    pwr_rst_status_in};
        for (i = 0; i < 5; i++) begin
            if (i < 4) bus_wr(ro_a[i], $random(seed));
            bus_rd(ro_a[i], r);
            chk("status word", ro_e[i], r & ~(i == 0 ? BANK_BIT : 32'h0));
        end
        $display("test status words done");
        bus_wr(OFF_SLEEP_EN, 32'h00000000);
        busy_a <= SLEEP_EN_MASK;
        busy_h <= 32'h00000000;
        busy_t <= 32'h00000000;
        bus_wr(OFF_HOST_SLEEP_EN, 32'hFFFFFFFF);
        bus_wr(OFF_SLEEP_EN_TWO, 32'hFFFFFFFF);
        bus_wr(OFF_SLEEP_EN, SLEEP_EN_MASK);
        repeat (4) @(posedge ref_clk);
        #1 chk("busy peripherals", 32'h00000000, periph_asleep);
        busy_a <= 32'h00000000;
        settle(1'b0, SLEEP_EN_MASK);
        timer_auto_reload <= 2'b11;
        settle(1'b0, SLEEP_EN_MASK & 32'h3FFFFFFF);
        timer_halted <= 2'b11;
        settle(1'b0, SLEEP_EN_MASK);
        cpu_sleep_instr <= 1'b1;
        settle(1'b1, 32'h00000001);
        bus_wr(OFF_SLEEP_EN, SLEEP_EN_MASK & ~(32'h1 << BIT_DMA));
        settle(1'b1, 32'h00000000);
        bus_wr(OFF_SYS_SLEEP_CTRL, 32'h00000008);
        settle(1'b1, 32'h00000001);
        chk("sleep all command", SLEEP_EN_MASK, sleep_cmd);
        chk("sleep all two", 32'hFFFFFFFF, sleep_cmd_two);
        $display("test sleep handshake done");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(OFF_SYS_SLEEP_CTRL, r);
        chk("control after reset", 32'h00000000, r);
        bus_rd(OFF_SLEEP_EN, r);
        chk("enable after reset", 32'h00000000, r);
        $display("test second reset done");
        conclude();
    end
endmodule : test_block_sleep_enable_bank

`default_nettype wire
